// ===== hdl/psu_smbus_slave_eeprom_port.sv
// supply management port: command responder and config eeprom on one link
// Function
// - device never starts a transfer
// - start and stop resync at any time
// - master clocks at most 100 kbps
// - stretch released within 1 ms
// - scl low over 25 ms is timeout
// - alert is or of shutdown, warning
// - alert low on fault, high healthy
// - responder answers address 0x20 only
// - eeprom answers address 0xA0 only
// - shared lines, each decodes own address
// - write protect high rejects eeprom writes
// - master prefers single-byte eeprom transfers
// - byte write: address, location, data, stop
// - master waits 5 ms after eeprom write
// - byte read: location, restart, read address
// - first byte is a command code
// - stop after code, byte or word
// - block writes up to 255 bytes; code takes the code byte plus 254 data bytes, then nacks
// - read byte and word served
// - block reads up to 255 bytes
module psu_smbus_slave_eeprom_port #(
  parameter int SCL_TMO_CYC = smbus_pkg::SCL_TMO_CYC,
  parameter int STRETCH_CYC = smbus_pkg::STRETCH_CYC
) (
  // clocks and reset
  input  wire logic       mclk_i,
  input  wire logic       link_clk_i,
  input  wire logic       rst_i,
  // two-wire link
  smbus_if.dev_mp         bus,
  // supply conditions
  input  wire logic [7:0] shutdown_evt_i,
  input  wire logic [7:0] warning_evt_i,
  // command user side
  output logic            msg_valid_o,
  output smbus_pkg::evt_e msg_kind_o,
  output logic [7:0]      msg_byte_o,
  output logic            rd_req_o,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i
);
  typedef enum logic [6:0] {
    D_IDLE  = 7'b0000001,
    D_ADDR  = 7'b0000010,
    D_RX    = 7'b0000100,
    D_ACK   = 7'b0001000,
    D_TX    = 7'b0010000,
    D_TACK  = 7'b0100000,
    D_FETCH = 7'b1000000
  } dstate_e;

  // link-side state, all on link_clk_i
  typedef struct packed {
    dstate_e         st;
    logic [2:0]      scl_p;
    logic [2:0]      sda_p;
    logic [1:0]      wp_p;
    logic [1:0]      ack_p;
    logic [3:0]      bits;
    logic [7:0]      sh;
    logic            tgt_cmd;
    logic            rd;
    logic            nack;
    logic [8:0]      nbytes;
    logic [7:0]      ptr;
    logic            sda_oe_n;
    logic            scl_oe_n;
    logic [31:0]     tmo;
    logic [31:0]     str;
    logic            pend;
    logic            wrote;
    logic            req_t;
    smbus_pkg::evt_e req_k;
    logic [7:0]      req_b;
    logic [smbus_pkg::EE_DEPTH-1:0][7:0] mem;
  } ln_s;

  // core-side state, all on mclk_i
  typedef struct packed {
    logic [2:0]      req_p;
    logic            ack_t;
    logic [7:0]      ans_b;
    logic            wait_rd;
    logic            msg_valid;
    smbus_pkg::evt_e msg_kind;
    logic [7:0]      msg_byte;
    logic            rd_req;
    logic            alert_n;
  } cr_s;

  ln_s        q;
  ln_s        n;
  cr_s        c;
  cr_s        cn;
  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic       busy;
  logic [7:0] rx_b;

  // hand one word to the core; the word holds still until acknowledged
  function automatic ln_s post(ln_s s, logic bsy, smbus_pkg::evt_e k, logic [7:0] b);
    ln_s r;
    r = s;
    if (!bsy) begin
      r.req_t = ~s.req_t;
      r.req_k = k;
      r.req_b = b;
    end
    return r;
  endfunction

  // load a byte for sending and put its msb on the line
  function automatic ln_s load_tx(ln_s s, logic [7:0] b);
    ln_s r;
    r          = s;
    r.st       = D_TX;
    r.sda_oe_n = b[7];
    r.sh       = {b[6:0], 1'b0};
    r.bits     = 4'h1;
    r.scl_oe_n = 1'b1;
    r.pend     = 1'b0;
    if (s.nbytes != 9'h1FF) r.nbytes = s.nbytes + 9'h1;
    return r;
  endfunction

  // next byte of a read: eeprom straight from memory, commands via the core
  function automatic ln_s next_rd(ln_s s);
    ln_s r;
    r = s;
    if (s.tgt_cmd) begin
      r.st       = D_FETCH;
      r.scl_oe_n = 1'b0;
      r.str      = '0;
    end else begin
      r     = load_tx(s, s.mem[s.ptr]);
      r.ptr = s.ptr + 8'h1;
    end
    return r;
  endfunction

  // edges seen on the second synchroniser stage and its delayed copy
  assign rise    = q.scl_p[1] & ~q.scl_p[2];
  assign fall    = ~q.scl_p[1] & q.scl_p[2];
  assign start_c = q.scl_p[1] & q.scl_p[2] & q.sda_p[2] & ~q.sda_p[1];
  assign stop_c  = q.scl_p[1] & q.scl_p[2] & ~q.sda_p[2] & q.sda_p[1];
  assign busy    = q.req_t ^ q.ack_p[1];
  assign rx_b    = {q.sh[6:0], q.sda_p[1]};

  // link protocol engine
  always_comb begin
    n       = q;
    n.scl_p = {q.scl_p[1:0], bus.scl};
    n.sda_p = {q.sda_p[1:0], bus.sda};
    n.wp_p  = {q.wp_p[0], bus.eeprom_wp};
    n.ack_p = {q.ack_p[0], c.ack_t};
    n.tmo   = q.scl_p[1] ? '0 : q.tmo + 32'h1;
    if (start_c || stop_c) begin
      if (q.wrote) n = post(n, busy, smbus_pkg::EV_END, 8'h00);
      n.wrote    = 1'b0;
      n.st       = start_c ? D_ADDR : D_IDLE;
      n.bits     = 4'h0;
      n.sda_oe_n = 1'b1;
      n.scl_oe_n = 1'b1;
      n.pend     = 1'b0;
    end else if (q.tmo >= 32'(SCL_TMO_CYC)) begin
      // abandon the transfer at once, well inside the recovery interval
      n.st       = D_IDLE;
      n.wrote    = 1'b0;
      n.sda_oe_n = 1'b1;
      n.scl_oe_n = 1'b1;
      n.pend     = 1'b0;
    end else begin
      unique case (q.st)
        D_IDLE: begin
        end
        D_ADDR, D_RX: begin
          if (rise) begin
            n.sh   = rx_b;
            n.bits = q.bits + 4'h1;
            if (q.bits == 4'h7) begin
              n.st   = D_ACK;
              n.nack = 1'b0;
              if (q.st == D_ADDR) begin
                n.rd     = rx_b[0];
                n.nbytes = 9'h0;
                if (rx_b[7:1] == smbus_pkg::CMD_ADDR[7:1]) n.tgt_cmd = 1'b1;
                else if (rx_b[7:1] == smbus_pkg::EE_ADDR[7:1]) n.tgt_cmd = 1'b0;
                else n.st = D_IDLE;
              end else begin
                if (q.nbytes != 9'h1FF) n.nbytes = q.nbytes + 9'h1;
                if (!q.tgt_cmd) begin
                  if (q.nbytes == 9'h0) n.ptr = rx_b;
                  else if (q.wp_p[1]) n.nack = 1'b1;
                  else begin
                    n.mem[q.ptr] = rx_b;
                    n.ptr        = q.ptr + 8'h1;
                  end
                end else begin
                  n.wrote = 1'b1;
                  if (q.nbytes == 9'h0) n = post(n, busy, smbus_pkg::EV_CODE, rx_b);
                  else if (q.nbytes >= 9'(smbus_pkg::MAX_BLOCK)) n.nack = 1'b1;
                  else n = post(n, busy, smbus_pkg::EV_DATA, rx_b);
                end
              end
            end
          end
        end
        D_ACK: begin
          if (fall && q.bits == 4'h8) begin
            n.sda_oe_n = q.nack; // only ever pulls low inside a slot it owns
            n.bits     = 4'h9;
          end else if (fall) begin
            n.sda_oe_n = 1'b1;
            n.bits     = 4'h0;
            if (q.nack) n.st = D_IDLE;
            else if (q.rd) n = next_rd(n);
            else n.st = D_RX;
          end
        end
        D_TX: begin
          if (fall && q.bits == 4'h8) begin
            n.sda_oe_n = 1'b1;
            n.bits     = 4'h0;
            n.st       = D_TACK;
          end else if (fall) begin
            n.sda_oe_n = q.sh[7];
            n.sh       = {q.sh[6:0], 1'b0};
            n.bits     = q.bits + 4'h1;
          end
        end
        D_TACK: begin
          // master nack ends the read; wait for its stop
          if (rise) begin
            if (q.sda_p[1]) n.st = D_IDLE;
            else n.bits = 4'h1;
          end else if (fall && q.bits == 4'h1) begin
            n = next_rd(n);
          end
        end
        D_FETCH: begin
          // scl is held low while the core supplies the byte
          n.str = q.str + 32'h1;
          if (q.nbytes >= 9'(smbus_pkg::MAX_BLOCK)) n = load_tx(n, smbus_pkg::IDLE_BYTE);
          else if (q.pend && !busy) n = load_tx(n, c.ans_b);
          else if (q.str >= 32'(STRETCH_CYC)) n = load_tx(n, smbus_pkg::IDLE_BYTE);
          else if (!q.pend && !busy) begin
            n      = post(n, busy, smbus_pkg::EV_RDREQ, q.nbytes[7:0]);
            n.pend = 1'b1;
          end
        end
      endcase
    end
  end

  // link-domain register
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st: D_IDLE, scl_p: 3'h7, sda_p: 3'h7, wp_p: 2'h3, sda_oe_n: 1'b1,
             scl_oe_n: 1'b1, req_k: smbus_pkg::EV_CODE, default: '0};
    end else begin
      q <= n;
    end
  end

  // core side: catch link words by toggle, answer reads, build the alert
  always_comb begin
    cn           = c;
    cn.req_p     = {c.req_p[1:0], q.req_t};
    cn.msg_valid = 1'b0;
    cn.rd_req    = 1'b0;
    cn.alert_n   = ~(|shutdown_evt_i | |warning_evt_i);
    if (c.req_p[1] ^ c.req_p[2]) begin
      // word is stable here: the link holds it until the ack toggles back
      cn.msg_valid = 1'b1;
      cn.msg_kind  = q.req_k;
      cn.msg_byte  = q.req_b;
      if (q.req_k == smbus_pkg::EV_RDREQ) begin
        cn.rd_req  = 1'b1;
        cn.wait_rd = 1'b1;
      end else begin
        cn.ack_t = ~c.ack_t;
      end
    end else if (c.wait_rd && rd_valid_i) begin
      cn.ans_b   = rd_data_i;
      cn.ack_t   = ~c.ack_t;
      cn.wait_rd = 1'b0;
    end
  end

  // core-domain register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      c <= '{msg_kind: smbus_pkg::EV_CODE, alert_n: 1'b1, default: '0};
    end else begin
      c <= cn;
    end
  end

  assign bus.dev_scl_o         = 1'b0;
  assign bus.dev_sda_o         = 1'b0;
  assign bus.dev_scl_oe_n      = q.scl_oe_n;
  assign bus.dev_sda_oe_n      = q.sda_oe_n;
  assign bus.fault_alert_out_n = c.alert_n;
  assign msg_valid_o           = c.msg_valid;
  assign msg_kind_o            = c.msg_kind;
  assign msg_byte_o            = c.msg_byte;
  assign rd_req_o              = c.rd_req;
endmodule

// ===== hdl/smbus_if.sv
// open-drain two-wire link between the supply port and its management master
interface smbus_if;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic scl;
  logic sda;
  logic eeprom_wp;
  logic fault_alert_out_n;
  // wired-and of both parties; a released line floats high on the pull-up
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);
  modport dev_mp (input scl, sda, eeprom_wp,
                  output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n, fault_alert_out_n);
  modport host_mp (input scl, sda, fault_alert_out_n,
                   output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, eeprom_wp);
endinterface

// ===== hdl/smbus_mgmt_master.sv
// management master: byte-level operations, scl made by dividing mclk
module smbus_mgmt_master #(
  parameter int EE_WR_CYC = smbus_pkg::EE_WR_CYC
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // two-wire link
  smbus_if.host_mp        bus,
  // operation request, one byte operation at a time
  input  wire logic       op_valid_i,
  input  wire logic [2:0] op_i,
  input  wire logic [7:0] op_byte_i,
  output logic            op_ready_o,
  // eeprom write enable level
  input  wire logic       wr_enable_i,
  // results
  output logic [7:0]      rd_byte_o,
  output logic            rd_valid_o,
  output logic            nack_o,
  output logic            alert_o
);
  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_START = 5'b00010,
    H_BIT   = 5'b00100,
    H_STOP  = 5'b01000,
    H_GUARD = 5'b10000
  } hstate_e;

  typedef struct packed {
    hstate_e     st;
    logic [1:0]  step;
    logic [31:0] cnt;
    logic [3:0]  bits;
    logic [8:0]  sh;
    logic        rd;
    logic [1:0]  scl_p;
    logic [1:0]  sda_p;
    logic [1:0]  al_p;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        wp;
    logic        ready;
    logic        rd_valid;
    logic        nack;
    logic        alert;
    logic [7:0]  rd_byte;
    logic        first;
    logic        ee_tgt;
    logic [1:0]  ee_n;
  } hs_s;

  hs_s  q;
  hs_s  n;
  logic half_done;
  logic mid;

  assign half_done = q.cnt == 32'(smbus_pkg::HALF_CYC - 1);
  assign mid       = q.cnt == 32'(smbus_pkg::HALF_CYC / 2);

  // one step of the bus sequencer
  always_comb begin
    n          = q;
    n.scl_p    = {q.scl_p[0], bus.scl};
    n.sda_p    = {q.sda_p[0], bus.sda};
    n.al_p     = {q.al_p[0], bus.fault_alert_out_n};
    n.alert    = ~q.al_p[1];
    n.wp       = ~wr_enable_i;
    n.rd_valid = 1'b0;
    n.cnt      = q.cnt + 32'h1;
    unique case (q.st)
      H_IDLE: begin
        n.cnt = '0;
        // one byte per request keeps single-byte transfers the natural form
        if (q.ready && op_valid_i) begin
          n.ready = 1'b0;
          n.step  = 2'h0;
          n.bits  = 4'h0;
          if (op_i == smbus_pkg::OP_START) begin
            n.st    = H_START;
            n.first = 1'b1;
          end else if (op_i == smbus_pkg::OP_STOP) begin
            n.st = H_STOP;
          end else begin
            n.st = H_BIT;
            n.rd = op_i != smbus_pkg::OP_WRITE;
            n.sh = (op_i == smbus_pkg::OP_WRITE) ? {op_byte_i, 1'b1}
                                                  : {8'hFF, op_i == smbus_pkg::OP_RD_NACK};
          end
        end
      end
      H_BIT: begin
        if (q.step == 2'h0) begin
          // data moves mid-low so the slave never sees it race the falling clock
          if (mid) n.sda_oe_n = q.sh[8];
          if (half_done) begin
            n.scl_oe_n = 1'b1;
            n.step     = 2'h1;
            n.cnt      = '0;
          end
        end else if (!q.scl_p[1]) begin
          n.cnt = '0; // slave is stretching
        end else if (half_done) begin
          n.scl_oe_n = 1'b0;
          n.sh       = {q.sh[7:0], q.sda_p[1]};
          n.bits     = q.bits + 4'h1;
          n.step     = 2'h0;
          n.cnt      = '0;
          if (q.bits == 4'h8) begin
            n.st    = H_IDLE;
            n.ready = 1'b1;
            n.first = 1'b0;
            if (q.rd) begin
              n.rd_byte  = q.sh[7:0];
              n.rd_valid = 1'b1;
            end else begin
              n.nack = q.sda_p[1];
              if (q.first) begin
                n.ee_tgt = q.sh[7:0] == smbus_pkg::EE_ADDR;
                n.ee_n   = 2'h0;
              end else if (q.ee_tgt && q.ee_n != 2'h2) begin
                n.ee_n = q.ee_n + 2'h1;
              end
            end
          end
        end
      end
      H_START: begin
        if (q.step == 2'h0) begin
          if (mid) n.sda_oe_n = 1'b1;
          if (half_done) begin
            n.scl_oe_n = 1'b1;
            n.step     = 2'h1;
            n.cnt      = '0;
          end
        end else if (q.step == 2'h1) begin
          if (!q.scl_p[1]) n.cnt = '0;
          else if (half_done) begin
            n.sda_oe_n = 1'b0; // start, or repeated start before a read address
            n.step     = 2'h2;
            n.cnt      = '0;
          end
        end else if (half_done) begin
          n.scl_oe_n = 1'b0;
          n.st       = H_IDLE;
          n.ready    = 1'b1;
        end
      end
      H_STOP: begin
        if (q.step == 2'h0) begin
          if (mid) n.sda_oe_n = 1'b0;
          if (half_done) begin
            n.scl_oe_n = 1'b1;
            n.step     = 2'h1;
            n.cnt      = '0;
          end
        end else if (q.step == 2'h1) begin
          if (!q.scl_p[1]) n.cnt = '0;
          else if (half_done) begin
            n.sda_oe_n = 1'b1;
            n.step     = 2'h2;
            n.cnt      = '0;
          end
        end else if (half_done) begin
          // pointer plus data went to the eeprom: hold off the next start
          n.st    = (q.ee_n == 2'h2) ? H_GUARD : H_IDLE;
          n.ready = q.ee_n != 2'h2;
          n.ee_n  = 2'h0;
          n.cnt   = '0;
        end
      end
      H_GUARD: begin
        if (q.cnt >= 32'(EE_WR_CYC - 1)) begin
          n.st    = H_IDLE;
          n.ready = 1'b1;
        end
      end
    endcase
  end

  // single state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st: H_IDLE, scl_p: 2'h3, sda_p: 2'h3, al_p: 2'h3, scl_oe_n: 1'b1,
             sda_oe_n: 1'b1, wp: 1'b1, ready: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_scl_oe_n = q.scl_oe_n;
  assign bus.host_sda_oe_n = q.sda_oe_n;
  assign bus.eeprom_wp     = q.wp;
  assign op_ready_o        = q.ready;
  assign rd_byte_o         = q.rd_byte;
  assign rd_valid_o        = q.rd_valid;
  assign nack_o            = q.nack;
  assign alert_o           = q.alert;
endmodule

// ===== hdl/smbus_pkg.sv
// shared constants and types for the supply management link
package smbus_pkg;
  // clock periods
  localparam int MCLK_NS       = 8;
  localparam int LINK_NS       = 160;
  // fixed target address bytes, r/w bit clear
  localparam logic [7:0] CMD_ADDR = 8'h20;
  localparam logic [7:0] EE_ADDR  = 8'hA0;
  // bus timing figures
  localparam int SCL_KBPS      = 100;
  localparam int SCL_TMO_MS    = 25;
  localparam int RECOVER_MS    = 10;
  localparam int STRETCH_MS    = 1;
  localparam int EE_WR_MS      = 5;
  // cycle counts: least times round up, longest times round down
  localparam int SCL_TMO_CYC   = (SCL_TMO_MS * 1000000 + LINK_NS - 1) / LINK_NS;
  localparam int STRETCH_CYC   = (STRETCH_MS * 1000000) / LINK_NS;
  localparam int EE_WR_CYC     = (EE_WR_MS * 1000000 + MCLK_NS - 1) / MCLK_NS;
  localparam int HALF_CYC      = (1000000 / SCL_KBPS / 2 + MCLK_NS - 1) / MCLK_NS;
  // message limits and fill values
  localparam int         MAX_BLOCK = 255;
  localparam int         EE_DEPTH  = 256;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // events handed from the link to the command user
  typedef enum logic [1:0] {
    EV_CODE  = 2'h0,
    EV_DATA  = 2'h1,
    EV_END   = 2'h2,
    EV_RDREQ = 2'h3
  } evt_e;
  // master byte operations
  typedef enum logic [2:0] {
    OP_START   = 3'h0,
    OP_WRITE   = 3'h1,
    OP_RD_ACK  = 3'h2,
    OP_RD_NACK = 3'h3,
    OP_STOP    = 3'h4
  } op_e;
endpackage

// ===== test/smbus_chk.sv
// concurrent checks on the link between the supply port and its master
module smbus_chk #(
  parameter int SCL_TMO_CYC = 400,
  parameter int STRETCH_CYC = 100
) (
  // clocks and reset
  input  wire logic       mclk_i,
  input  wire logic       link_clk_i,
  input  wire logic       rst_i,
  // link lines
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       dev_scl_oe_n,
  input  wire logic       dev_sda_oe_n,
  // supply conditions and alert
  input  wire logic [7:0] shutdown_evt_i,
  input  wire logic [7:0] warning_evt_i,
  input  wire logic       fault_alert_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // margin covers the two-stage sampling of scl
  localparam int TMO_LIM = SCL_TMO_CYC + 8;
  logic [15:0] tmo_cnt_ff;
  logic [15:0] str_cnt_ff;
  logic [7:0]  cond;
  // any condition bit, shutdown or warning
  assign cond = shutdown_evt_i | warning_evt_i;
  // scl low time and stretch time in link clocks
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmo_cnt_ff <= 16'h0;
      str_cnt_ff <= 16'h0;
    end else begin
      tmo_cnt_ff <= scl ? 16'h0 : tmo_cnt_ff + 16'h1;
      str_cnt_ff <= dev_scl_oe_n ? 16'h0 : str_cnt_ff + 16'h1;
    end
  end
  a_start_not_dev: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(sda) && scl && $past(scl) |-> dev_sda_oe_n) else $error("device pulled sda for a start");
  a_stop_idle_sda: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(sda) && scl && $past(scl) |=> dev_sda_oe_n [*8]) else $error("device drove sda after stop");
  a_sda_on_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl)) else $error("device moved sda while scl high");
  a_hold_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(dev_scl_oe_n) |-> !scl && !$past(scl)) else $error("device grabbed scl while high");
  a_stretch_bound: assert property (@(posedge link_clk_i) disable iff (rst_i)
    str_cnt_ff <= STRETCH_CYC + 4) else $error("clock stretch too long");
  a_tmo_release: assert property (@(posedge link_clk_i) disable iff (rst_i)
    tmo_cnt_ff >= TMO_LIM |-> dev_scl_oe_n && dev_sda_oe_n) else $error("lines held after timeout");
  a_tmo_resume: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(scl) && $past(tmo_cnt_ff) >= TMO_LIM |-> dev_sda_oe_n [*4]) else $error("stale drive after timeout");
  a_alert_or: assert property (@(posedge mclk_i) disable iff (rst_i)
    !$past(rst_i) |-> fault_alert_out_n == ($past(cond) == 8'h0)) else $error("alert not or of conditions");
  c_stretch: cover property (@(posedge link_clk_i) str_cnt_ff == 16'h32);
  c_timeout: cover property (@(posedge link_clk_i) tmo_cnt_ff == TMO_LIM);
  c_alert: cover property (@(posedge mclk_i) $fell(fault_alert_out_n));
endmodule

// ===== test/testbench.sv
// self-checking bench: supply port and master joined on one link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         TMO = 400;
  localparam int         STR = 100;
  localparam logic [2:0] ST  = smbus_pkg::OP_START;
  localparam logic [2:0] SP  = smbus_pkg::OP_STOP;
  localparam logic [7:0] CA  = smbus_pkg::CMD_ADDR;
  localparam logic [7:0] EA  = smbus_pkg::EE_ADDR;
  logic            mclk_i = 1'b0;
  logic            link_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            op_valid_i = 1'b0;
  logic [2:0]      op_i = 3'h0;
  logic [7:0]      op_byte_i = 8'h00;
  logic            wr_enable_i = 1'b0;
  logic [7:0]      shutdown_evt_i = 8'h00;
  logic [7:0]      warning_evt_i = 8'h00;
  logic            rd_valid_i = 1'b0;
  logic [7:0]      rd_data_i = 8'h00;
  logic            op_ready_o, nack_o, alert_o, msg_valid_o, rd_req_o;
  logic [7:0]      rd_byte_o, msg_byte_o, a, b, c, loc;
  smbus_pkg::evt_e msg_kind_o;
  int              miscompares = 0;
  int              n_compared = 0;
  int              late = 0;
  logic [31:0]     seed = 32'h743BFAEF;
  logic [7:0]      mem [256] = '{default: 8'h00};
  logic [9:0]      evq [$];
  logic [8:0]      rdq [$];
  smbus_if bus ();
  psu_smbus_slave_eeprom_port #(.SCL_TMO_CYC(TMO), .STRETCH_CYC(STR)) i_psu_smbus_slave_eeprom_port (
    .mclk_i(mclk_i), .link_clk_i(link_clk_i), .rst_i(rst_i), .bus(bus), .shutdown_evt_i(shutdown_evt_i),
    .warning_evt_i(warning_evt_i), .msg_valid_o(msg_valid_o), .msg_kind_o(msg_kind_o), .msg_byte_o(msg_byte_o),
    .rd_req_o(rd_req_o), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i));
  smbus_mgmt_master #(.EE_WR_CYC(5000)) i_smbus_mgmt_master (
    .mclk_i(mclk_i), .rst_i(rst_i), .bus(bus), .op_valid_i(op_valid_i), .op_i(op_i), .op_byte_i(op_byte_i),
    .op_ready_o(op_ready_o), .wr_enable_i(wr_enable_i), .rd_byte_o(rd_byte_o), .rd_valid_o(),
    .nack_o(nack_o), .alert_o(alert_o));
  smbus_chk #(.SCL_TMO_CYC(TMO), .STRETCH_CYC(STR)) i_smbus_chk (.mclk_i(mclk_i), .link_clk_i(link_clk_i),
    .rst_i(rst_i), .scl(bus.scl), .sda(bus.sda), .dev_scl_oe_n(bus.dev_scl_oe_n), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .shutdown_evt_i(shutdown_evt_i), .warning_evt_i(warning_evt_i), .fault_alert_out_n(bus.fault_alert_out_n));
  // main clock, and a link clock with an odd phase offset
  always #4 mclk_i = ~mclk_i;
  initial begin
    #37;
    forever #80 link_clk_i = ~link_clk_i;
  end
  // xorshift source of stimulus bytes
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait on the master's ready level, sampled at falling edges
  task automatic wait_ready(input logic lvl, input int lim);
    int n = 0;
    while (op_ready_o !== lvl) begin
      @(negedge mclk_i);
      n++;
      if (n > lim) begin
        miscompares++;
        final_report();
      end
    end
  endtask
  // one byte operation; valid is held until the taking edge has passed
  task automatic op(input logic [2:0] k, input logic [7:0] d);
    op_valid_i = 1'b1;
    op_i = k;
    op_byte_i = d;
    wait_ready(1'b1, 8);
    @(negedge mclk_i);
    op_valid_i = 1'b0;
    wait_ready(1'b0, 4);
    wait_ready(1'b1, 40000);
  endtask
  task automatic wr(input logic [7:0] d, input logic nk);
    op(smbus_pkg::OP_WRITE, d);
    chk("ack bit", nack_o, nk);
  endtask
  task automatic rd(input logic last, input logic [7:0] exp);
    op(last ? smbus_pkg::OP_RD_NACK : smbus_pkg::OP_RD_ACK, 8'h00);
    chk("read byte", rd_byte_o, exp);
  endtask
  task automatic ee_write(input logic [7:0] l, input logic [7:0] d, input logic nk);
    op(ST, 8'h00);
    wr(EA, 1'b0);
    wr(l, 1'b0);
    wr(d, nk);
    op(SP, 8'h00);
  endtask
  // command user: match each event, answer byte requests at once or late
  always @(negedge mclk_i) begin
    logic [8:0] ans;
    ans = 9'h000;
    if (msg_valid_o === 1'b1) begin
      chk("event", {msg_kind_o, msg_byte_o}, evq.size() > 0 ? evq.pop_front() : 10'h3FF);
      if (rd_req_o === 1'b1 && rdq.size() > 0)
        ans = rdq.pop_front();
      if (rd_req_o === 1'b1 && ans[8] == 1'b0)
        late = 3000;
    end else if (late > 0) begin
      late--;
      if (late == 0) ans = 9'h1AA;
    end
    rd_valid_i <= ans[8];
    rd_data_i <= ans[7:0];
  end
  initial begin
    // reset spans three edges of the slower link clock
    repeat (3) @(posedge link_clk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    @(negedge mclk_i);
    chk("write protect", bus.eeprom_wp, 1'b1);
    for (int i = 0; i < 12; i++) begin
      a = rnd();
      b = rnd();
      c = rnd();
      shutdown_evt_i = c[0] ? a : 8'h00;
      warning_evt_i = c[1] ? b : 8'h00;
      repeat (6) @(negedge mclk_i);
      chk("alert line", bus.fault_alert_out_n, (shutdown_evt_i | warning_evt_i) == 8'h00);
      chk("alert seen", alert_o, (shutdown_evt_i | warning_evt_i) != 8'h00);
    end
    shutdown_evt_i = 8'h00;
    warning_evt_i = 8'h00;
    // store with protection off, then a refused store to the same place
    loc = rnd();
    a = rnd();
    wr_enable_i = 1'b1;
    @(negedge mclk_i);
    chk("write protect", bus.eeprom_wp, 1'b0);
    ee_write(loc, a, 1'b0);
    mem[loc] = a;
    wr_enable_i = 1'b0;
    ee_write(loc, ~a, 1'b1);
    // random read with repeated start
    op(ST, 8'h00);
    wr(EA, 1'b0);
    wr(loc, 1'b0);
    op(ST, 8'h00);
    wr(EA | 8'h01, 1'b0);
    rd(1'b1, mem[loc]);
    op(SP, 8'h00);
    // a neighbour of the command address is ignored
    op(ST, 8'h00);
    wr(8'h22, 1'b1);
    op(SP, 8'h00);
    // write-word command
    a = rnd();
    b = rnd();
    c = rnd();
    evq = '{{smbus_pkg::EV_CODE, a}, {smbus_pkg::EV_DATA, b}, {smbus_pkg::EV_DATA, c}, {smbus_pkg::EV_END, 8'h00}};
    op(ST, 8'h00);
    wr(CA, 1'b0);
    wr(a, 1'b0);
    wr(b, 1'b0);
    wr(c, 1'b0);
    op(SP, 8'h00);
    // read-word command; the second byte is answered late, so the stretch expires
    a = rnd();
    b = rnd();
    evq = '{{smbus_pkg::EV_CODE, a}, {smbus_pkg::EV_END, 8'h00}, {smbus_pkg::EV_RDREQ, 8'h00},
            {smbus_pkg::EV_RDREQ, 8'h01}};
    rdq = '{{1'b1, b}, 9'h000};
    op(ST, 8'h00);
    wr(CA, 1'b0);
    wr(a, 1'b0);
    op(ST, 8'h00);
    wr(CA | 8'h01, 1'b0);
    rd(1'b0, b);
    rd(1'b1, smbus_pkg::IDLE_BYTE);
    op(SP, 8'h00);
    // sequential read left hanging with scl low: device drives a zero bit, then must let go
    op(ST, 8'h00);
    wr(EA | 8'h01, 1'b0);
    repeat ((TMO + 40) * 20) @(negedge mclk_i);
    chk("sda after timeout", bus.sda, 1'b1);
    chk("scl drive after timeout", bus.dev_scl_oe_n, 1'b1);
    // send-byte command right after the timeout
    a = rnd();
    evq = '{{smbus_pkg::EV_CODE, a}, {smbus_pkg::EV_END, 8'h00}};
    op(ST, 8'h00);
    wr(CA, 1'b0);
    wr(a, 1'b0);
    op(SP, 8'h00);
    repeat (40) @(negedge mclk_i);
    chk("events left", evq.size(), 10'h000);
    final_report();
  end
endmodule
